// [rtl/adc_result_alert_config_regs.sv]
// Notes on behaviour
// - Result is 12-bit binary, bits 14:12 zero
// - Result read-only at pointer 0, resets zero
// - Bit 15 shows alert when tag enabled
// - Over flag sets when sample exceeds upper
// - No hold: over clears below upper minus hysteresis
// - Writing one clears over; only way under hold
// - Under flag sets when sample below lower
// - No hold: under clears above lower plus hysteresis
// - Writing one clears under; only way under hold
// - Status at pointer 1, resets zero, 7:2 zero
// - Config at pointer 2; cycle code 0 disables
// - Codes 1..7 give x32 to x2048 intervals
// - Config bit 4 is the hold bit
// - Config bit 3 enables result alert tag
// - Config bit 2 enables pin, else released
// - Config bit 0 polarity; bit 1 reads zero
// - First write byte loads three-bit pointer
// - Upper limit resets to full scale
`timescale 1ns/100ps
`default_nettype none
`include "adcrac_defs.svh"
module adc_result_alert_config_regs
    import adcrac_pkg::*;
#(
    parameter int CONV_CYCLES = `ADCRAC_CONV_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      ptrWrite,
    input  wire logic                      regWrite,
    input  wire logic [`ADCRAC_REG_W-1:0]  wrData,
    input  wire logic                      resultRead,
    input  wire logic                      convDone,
    input  wire logic [`ADCRAC_DATA_W-1:0] convData,
    output logic [`ADCRAC_REG_W-1:0]       readData,
    output logic                           convStart,
    output logic                           alertPin,
    output logic                           alertOe
);
    logic [`ADCRAC_PTR_W-1:0]  pointer;
    logic [`ADCRAC_DATA_W-1:0] result;
    logic [7:0]                configuration;
    logic [`ADCRAC_DATA_W-1:0] lowLimit;
    logic [`ADCRAC_DATA_W-1:0] highLimit;
    logic [`ADCRAC_DATA_W-1:0] hysteresisValue;
    logic                      overFlag;
    logic                      underFlag;
    logic                      autoTick;
    logic                      evalStrobe;
    logic                      statusWrite;
    logic                      anyAlert;
    logic [`ADCRAC_REG_W-1:0]  next_readData;
    adcrac_state_t             state;

    assign evalStrobe  = convDone && state == ADCRAC_BUSY;
    assign statusWrite = regWrite && pointer == `ADCRAC_PTR_STATUS;
    assign anyAlert    = overFlag || underFlag;

    // Pointer keeps only its three low bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pointer <= `ADCRAC_PTR_RESULT;
        end else if (ptrWrite) begin
            pointer <= wrData[`ADCRAC_PTR_W-1:0];
        end
    end

    // Writable registers; result is not reachable from the bus
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            configuration   <= `ADCRAC_CONFIG_RST;
            lowLimit        <= `ADCRAC_LOWLIM_RST;
            highLimit       <= `ADCRAC_HIGHLIM_RST;
            hysteresisValue <= `ADCRAC_HYST_RST;
        end else if (regWrite) begin
            case (pointer)
                `ADCRAC_PTR_CONFIG: begin
                    configuration <= wrData[7:0] & 8'hFD;
                end
                `ADCRAC_PTR_LOWLIM: begin
                    lowLimit <= wrData[`ADCRAC_DATA_W-1:0];
                end
                `ADCRAC_PTR_HIGHLIM: begin
                    highLimit <= wrData[`ADCRAC_DATA_W-1:0];
                end
                `ADCRAC_PTR_HYST: begin
                    hysteresisValue <= wrData[`ADCRAC_DATA_W-1:0];
                end
                default: begin
                    configuration <= configuration;
                end
            endcase
        end
    end

    // Conversion handshake; a read or an interval tick starts one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= ADCRAC_IDLE;
            convStart <= 1'b0;
        end else begin
            convStart <= 1'b0;
            case (state)
                ADCRAC_IDLE: begin
                    if (autoTick || resultRead) begin
                        state     <= ADCRAC_BUSY;
                        convStart <= 1'b1;
                    end
                end
                ADCRAC_BUSY: begin
                    if (convDone) begin
                        state <= ADCRAC_IDLE;
                    end
                end
                default: begin
                    state <= ADCRAC_IDLE;
                end
            endcase
        end
    end

    // Latest conversion; ticks during a busy conversion are dropped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result <= `ADCRAC_RESULT_RST;
        end else if (evalStrobe) begin
            result <= convData;
        end
    end

    adcrac_interval #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_interval (
        .clk     (clk),
        .sys_rst (sys_rst),
        .code    (configuration[`ADCRAC_CFG_CYCLE_HI:`ADCRAC_CFG_CYCLE_LO]),
        .tick    (autoTick)
    );

    adcrac_flag #(
        .OVER (1'b1)
    ) u_over (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .evalStrobe (evalStrobe),
        .sample     (convData),
        .limit      (highLimit),
        .hyst       (hysteresisValue),
        .hold       (configuration[`ADCRAC_CFG_HOLD_BIT]),
        .swClear    (statusWrite && wrData[`ADCRAC_ST_OVER_BIT]),
        .flag       (overFlag)
    );

    adcrac_flag #(
        .OVER (1'b0)
    ) u_under (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .evalStrobe (evalStrobe),
        .sample     (convData),
        .limit      (lowLimit),
        .hyst       (hysteresisValue),
        .hold       (configuration[`ADCRAC_CFG_HOLD_BIT]),
        .swClear    (statusWrite && wrData[`ADCRAC_ST_UNDER_BIT]),
        .flag       (underFlag)
    );

    // Read mux; unused and unmapped bits read zero
    always_comb begin
        next_readData = '0;
        case (pointer)
            `ADCRAC_PTR_RESULT: begin
                next_readData[`ADCRAC_DATA_W-1:0]  = result;
                next_readData[`ADCRAC_RES_TAG_BIT] = configuration[`ADCRAC_CFG_TAG_BIT]
                    && anyAlert;
            end
            `ADCRAC_PTR_STATUS: begin
                next_readData[1:0] = {overFlag, underFlag};
            end
            `ADCRAC_PTR_CONFIG: begin
                next_readData[7:0] = configuration;
            end
            `ADCRAC_PTR_LOWLIM: begin
                next_readData[`ADCRAC_DATA_W-1:0] = lowLimit;
            end
            `ADCRAC_PTR_HIGHLIM: begin
                next_readData[`ADCRAC_DATA_W-1:0] = highLimit;
            end
            `ADCRAC_PTR_HYST: begin
                next_readData[`ADCRAC_DATA_W-1:0] = hysteresisValue;
            end
            default: begin
                next_readData = '0;
            end
        endcase
    end

    // Registered so the serial engine sees a steady word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readData <= '0;
        end else begin
            readData <= next_readData;
        end
    end

    // Alert pin level and enable; released pin is left to the pad
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alertPin <= 1'b1;
            alertOe  <= 1'b0;
        end else begin
            alertPin <= configuration[`ADCRAC_CFG_POL_BIT] ? anyAlert : !anyAlert;
            alertOe  <= configuration[`ADCRAC_CFG_PIN_BIT];
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_result_reserved;
        pointer == `ADCRAC_PTR_RESULT |=> readData[14:12] == 3'h0 && readData[11:0] == $past(result);
    endproperty
    a_result_reserved: assert property (p_result_reserved) else $error("result word wrong");

    property p_result_hold;
        !evalStrobe |=> $stable(result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed without conversion");

    property p_tag;
        pointer == `ADCRAC_PTR_RESULT |=>
            readData[15] == ($past(configuration[`ADCRAC_CFG_TAG_BIT]) && $past(anyAlert));
    endproperty
    a_tag: assert property (p_tag) else $error("alert tag wrong");

    property p_over_set;
        evalStrobe && convData > highLimit |=> overFlag;
    endproperty
    a_over_set: assert property (p_over_set) else $error("over flag not set");

    property p_under_set;
        evalStrobe && convData < lowLimit |=> underFlag;
    endproperty
    a_under_set: assert property (p_under_set) else $error("under flag not set");

    property p_over_hyst;
        evalStrobe && !configuration[`ADCRAC_CFG_HOLD_BIT] && convData <= highLimit
            && ({1'b0, convData} + {1'b0, hysteresisValue}) < {1'b0, highLimit} |=> !overFlag;
    endproperty
    a_over_hyst: assert property (p_over_hyst) else $error("over flag not self-cleared");

    property p_hold_keeps;
        configuration[`ADCRAC_CFG_HOLD_BIT] && overFlag
            && !(statusWrite && wrData[`ADCRAC_ST_OVER_BIT]) |=> overFlag;
    endproperty
    a_hold_keeps: assert property (p_hold_keeps) else $error("held over flag lost");

    property p_w1c_under;
        statusWrite && wrData[`ADCRAC_ST_UNDER_BIT] && !(evalStrobe && convData < lowLimit) |=> !underFlag;
    endproperty
    a_w1c_under: assert property (p_w1c_under) else $error("under flag not cleared");

    property p_status_reserved;
        pointer == `ADCRAC_PTR_STATUS |=> readData[15:2] == 14'h0000;
    endproperty
    a_status_reserved: assert property (p_status_reserved) else $error("status reserved bits set");

    property p_pin;
        anyAlert && configuration[`ADCRAC_CFG_PIN_BIT] |=>
            alertOe && alertPin == $past(configuration[`ADCRAC_CFG_POL_BIT]);
    endproperty
    a_pin: assert property (p_pin) else $error("alert pin not asserted");

    property p_reset_high;
        $past(sys_rst) |-> highLimit == `ADCRAC_HIGHLIM_RST && configuration == `ADCRAC_CONFIG_RST;
    endproperty
    a_reset_high: assert property (p_reset_high) else $error("reset values wrong");

    property p_result_load;
        evalStrobe |=> result == $past(convData);
    endproperty
    a_result_load: assert property (p_result_load) else $error("result not loaded");

    property p_result_ro;
        regWrite && pointer == `ADCRAC_PTR_RESULT && !evalStrobe |=> result == $past(result);
    endproperty
    a_result_ro: assert property (p_result_ro) else $error("result written from bus");

    property p_tag_off;
        pointer == `ADCRAC_PTR_RESULT && !configuration[`ADCRAC_CFG_TAG_BIT] |=> !readData[`ADCRAC_RES_TAG_BIT];
    endproperty
    a_tag_off: assert property (p_tag_off) else $error("alert tag shown while disabled");

    property p_w1c_over;
        statusWrite && wrData[`ADCRAC_ST_OVER_BIT] && !(evalStrobe && convData > highLimit) |=> !overFlag;
    endproperty
    a_w1c_over: assert property (p_w1c_over) else $error("over flag not cleared");

    property p_under_hyst;
        evalStrobe && !configuration[`ADCRAC_CFG_HOLD_BIT] && convData >= lowLimit
            && {1'b0, convData} > ({1'b0, lowLimit} + {1'b0, hysteresisValue}) |=> !underFlag;
    endproperty
    a_under_hyst: assert property (p_under_hyst) else $error("under flag not self-cleared");

    property p_hold_under;
        configuration[`ADCRAC_CFG_HOLD_BIT] && underFlag
            && !(statusWrite && wrData[`ADCRAC_ST_UNDER_BIT]) |=> underFlag;
    endproperty
    a_hold_under: assert property (p_hold_under) else $error("held under flag lost");

    property p_flags_quiet;
        !evalStrobe && !statusWrite |=> $stable(overFlag) && $stable(underFlag);
    endproperty
    a_flags_quiet: assert property (p_flags_quiet) else $error("flag moved between conversions");

    property p_status_read;
        pointer == `ADCRAC_PTR_STATUS |=> readData[1:0] == {$past(overFlag), $past(underFlag)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status word wrong");

    property p_cfg_write;
        regWrite && pointer == `ADCRAC_PTR_CONFIG |=> configuration == ($past(wrData[7:0]) & 8'hFD);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("configuration not written");

    property p_cfg_read;
        pointer == `ADCRAC_PTR_CONFIG |=> readData[15:8] == 8'h00 && readData[1] == 1'b0;
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("configuration reserved bits set");

    property p_auto_off;
        configuration[`ADCRAC_CFG_CYCLE_HI:`ADCRAC_CFG_CYCLE_LO] == 3'h0 && !resultRead
            && $past(configuration[`ADCRAC_CFG_CYCLE_HI:`ADCRAC_CFG_CYCLE_LO]) == 3'h0 |=> !convStart;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("start with automatic mode off");

    property p_pin_oe;
        1'b1 |=> alertOe == $past(configuration[`ADCRAC_CFG_PIN_BIT]);
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("alert enable wrong");

    property p_pin_idle;
        !anyAlert |=> alertPin == !$past(configuration[`ADCRAC_CFG_POL_BIT]);
    endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("alert pin not idle");

    property p_pointer;
        ptrWrite |=> pointer == $past(wrData[`ADCRAC_PTR_W-1:0]);
    endproperty
    a_pointer: assert property (p_pointer) else $error("pointer not loaded");

    cover property (evalStrobe && convData > highLimit);
    cover property (overFlag && configuration[`ADCRAC_CFG_HOLD_BIT] ##1 !overFlag);
    cover property (autoTick && state == ADCRAC_IDLE);
    cover property (readData[15]);
    cover property (underFlag && !configuration[`ADCRAC_CFG_HOLD_BIT] ##1 !underFlag);
endmodule
`default_nettype wire

// [rtl/adcrac_defs.svh]
`ifndef ADCRAC_DEFS_SVH
`define ADCRAC_DEFS_SVH

// Register pointers, three low bits of the pointer byte
`define ADCRAC_PTR_W          3
`define ADCRAC_PTR_RESULT     3'h0
`define ADCRAC_PTR_STATUS     3'h1
`define ADCRAC_PTR_CONFIG     3'h2
`define ADCRAC_PTR_LOWLIM     3'h3
`define ADCRAC_PTR_HIGHLIM    3'h4
`define ADCRAC_PTR_HYST       3'h5

// Widths
`define ADCRAC_DATA_W         12
`define ADCRAC_REG_W          16

// Reset values
`define ADCRAC_RESULT_RST     12'h000
`define ADCRAC_STATUS_RST     2'h0
`define ADCRAC_CONFIG_RST     8'h00
`define ADCRAC_LOWLIM_RST     12'h000
`define ADCRAC_HIGHLIM_RST    12'hFFF
`define ADCRAC_HYST_RST       12'h000

// Field positions
`define ADCRAC_RES_TAG_BIT    15
`define ADCRAC_ST_OVER_BIT    1
`define ADCRAC_ST_UNDER_BIT   0
`define ADCRAC_CFG_CYCLE_HI   7
`define ADCRAC_CFG_CYCLE_LO   5
`define ADCRAC_CFG_HOLD_BIT   4
`define ADCRAC_CFG_TAG_BIT    3
`define ADCRAC_CFG_PIN_BIT    2
`define ADCRAC_CFG_POL_BIT    0

// Timing: interval is one conversion time times 2**(code+4)
`define ADCRAC_CLK_NS         10
`define ADCRAC_TCONV_NS       1000
`define ADCRAC_CONV_CYCLES    ((`ADCRAC_TCONV_NS + `ADCRAC_CLK_NS - 1) / `ADCRAC_CLK_NS)
`define ADCRAC_SHIFT_BASE     5'h04
`define ADCRAC_CNT_W          24

`endif

// [rtl/adcrac_flag.sv]
`timescale 1ns/100ps
`default_nettype none
`include "adcrac_defs.svh"
module adcrac_flag #(
    parameter bit OVER = 1'b1
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      evalStrobe,
    input  wire logic [`ADCRAC_DATA_W-1:0] sample,
    input  wire logic [`ADCRAC_DATA_W-1:0] limit,
    input  wire logic [`ADCRAC_DATA_W-1:0] hyst,
    input  wire logic                      hold,
    input  wire logic                      swClear,
    output logic                           flag
);
    logic [`ADCRAC_DATA_W:0] sampleExt;
    logic [`ADCRAC_DATA_W:0] limitExt;
    logic [`ADCRAC_DATA_W:0] hystExt;
    logic                    setCond;
    logic                    clrCond;

    // One spare bit so sample or limit plus hysteresis never wraps
    assign sampleExt = {1'b0, sample};
    assign limitExt  = {1'b0, limit};
    assign hystExt   = {1'b0, hyst};
    assign setCond   = OVER ? (sample > limit) : (sample < limit);
    assign clrCond   = OVER ? ((sampleExt + hystExt) < limitExt) : (sampleExt > (limitExt + hystExt));

    // Set beats any clear arriving in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else if (evalStrobe && setCond) begin
            flag <= 1'b1;
        end else if (swClear) begin
            flag <= 1'b0;
        end else if (evalStrobe && !hold && clrCond) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [rtl/adcrac_interval.sv]
`timescale 1ns/100ps
`default_nettype none
`include "adcrac_defs.svh"
module adcrac_interval #(
    parameter int CONV_CYCLES = `ADCRAC_CONV_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] code,
    output logic            tick
);
    logic [`ADCRAC_CNT_W-1:0] period;
    logic [`ADCRAC_CNT_W-1:0] count;
    logic [4:0]               shiftAmt;

    // Code 1 gives x32, each step doubles up to x2048
    assign shiftAmt = 5'(code) + `ADCRAC_SHIFT_BASE;
    assign period   = `ADCRAC_CNT_W'(CONV_CYCLES) << shiftAmt;

    // Free-running interval; code 0 parks the counter
    always_ff @(posedge clk) begin
        if (sys_rst || code == 3'h0) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count >= period - `ADCRAC_CNT_W'(1)) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + `ADCRAC_CNT_W'(1);
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [rtl/adcrac_pkg.sv]
package adcrac_pkg;
    // Conversion handshake states, Gray along the path
    typedef enum logic [1:0] {
        ADCRAC_IDLE = 2'h0,
        ADCRAC_BUSY = 2'h1
    } adcrac_state_t;
endpackage

// [tb/adcrac_conv_model.sv]
`timescale 1ns/100ps
`default_nettype none
`include "adcrac_defs.svh"
module adcrac_conv_model (
    input  wire logic                      clk,
    input  wire logic                      convStart,
    input  wire logic [`ADCRAC_DATA_W-1:0] value,
    input  wire logic [7:0]                latency,
    output logic                           convDone,
    output logic [`ADCRAC_DATA_W-1:0]      convData
);
    // Answer each start after a set latency, prompt or slow
    initial begin
        convDone = 1'b0;
        convData = 12'h000;
        @(posedge clk);
        #1;
        // Start is looked at right after the done pulse too, so none is lost
        forever begin
            if (convStart === 1'b1) begin
                repeat (latency) @(posedge clk);
                #1;
                convDone = 1'b1;
                convData = value;
                @(posedge clk);
                #1;
                convDone = 1'b0;
                convData = ~value; // Stale data must not look valid
            end else begin
                @(posedge clk);
                #1;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "adcrac_defs.svh"
module tb_top;
    localparam int CONV = 2;
    logic        clk = 1'b0;
    logic        sysRst = 1'b1;
    logic        ptrWrite = 1'b0;
    logic        regWrite = 1'b0;
    logic [15:0] wrData = 16'h0000;
    logic        resultRead = 1'b0;
    logic        convDone;
    logic [11:0] convData;
    logic [15:0] readData;
    logic        convStart;
    logic        alertPin;
    logic        alertOe;
    logic [11:0] convValue = 12'h000;
    logic [7:0]  convLat = 8'h03;
    int          err_count = 0;
    int          n_checks = 0;

    // Clock, 10 ns period
    always #5 clk = ~clk;

    adc_result_alert_config_regs #(.CONV_CYCLES(CONV)) DUT (
        .clk(clk), .sys_rst(sysRst), .ptrWrite(ptrWrite), .regWrite(regWrite),
        .wrData(wrData), .resultRead(resultRead), .convDone(convDone), .convData(convData),
        .readData(readData), .convStart(convStart), .alertPin(alertPin), .alertOe(alertOe));

    adcrac_conv_model model (
        .clk(clk), .convStart(convStart), .value(convValue), .latency(convLat),
        .convDone(convDone), .convData(convData));

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Pointer byte first, then the data word
    task automatic setPtr(input logic [2:0] p);
        @(posedge clk);
        #1;
        ptrWrite = 1'b1;
        wrData = {13'h0000, p};
        @(posedge clk);
        #1;
        ptrWrite = 1'b0;
    endtask

    task automatic wrReg(input logic [2:0] p, input logic [15:0] d);
        setPtr(p);
        regWrite = 1'b1;
        wrData = d;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
    endtask

    // Read data settles one edge after the pointer loads; wait two
    task automatic rdReg(input logic [2:0] p, input logic [15:0] exp);
        setPtr(p);
        repeat (2) @(posedge clk);
        #1;
        chk16(readData, exp);
    endtask

    // Result read starts one conversion; wait for the answer
    task automatic convert(input logic [11:0] v);
        int i;
        convValue = v;
        @(posedge clk);
        #1;
        resultRead = 1'b1;
        @(posedge clk);
        #1;
        resultRead = 1'b0;
        // Strobe read at the edge the design takes it, not 1 ns later
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (convDone === 1'b1) break;
        end
        #1;
        chkBit(i < 100, 1'b1);
    endtask

    task automatic convChk(input logic [11:0] v, input logic [15:0] st);
        convert(v);
        rdReg(3'h1, st);
    endtask

    // Time of the next start pulse, -1 if none in the bound
    task automatic waitStart(input int bound, output int t);
        int i;
        t = -1;
        for (i = 0; i < bound; i++) begin
            @(posedge clk);
            #1;
            if (convStart === 1'b1) begin
                t = int'($time / 10);
                break;
            end
        end
    endtask

    task automatic testReset();
        chkBit(alertOe, 1'b0);
        chkBit(alertPin, 1'b1);
        rdReg(3'h0, 16'h0000);
        rdReg(3'h1, 16'h0000);
        rdReg(3'h2, 16'h0000);
        rdReg(3'h4, 16'h0FFF);
        $display("test reset done");
    endtask

    task automatic testReserved();
        wrReg(3'h2, 16'h001F);
        rdReg(3'h2, 16'h001D);
        chkBit(alertOe, 1'b1);
        chkBit(alertPin, 1'b0);
        wrReg(3'h1, 16'h00FC);
        rdReg(3'h1, 16'h0000);
        wrReg(3'h0, 16'h0ABC);
        rdReg(3'h0, 16'h0000);
        $display("test reserved done");
    endtask

    // Over range with self clear, strict bounds on both edges
    task automatic testOver();
        wrReg(3'h4, 16'h0800);
        wrReg(3'h5, 16'h0010);
        wrReg(3'h2, 16'h000D);
        convChk(12'h800, 16'h0000);
        convChk(12'h801, 16'h0002);
        rdReg(3'h0, 16'h8801);
        chkBit(alertPin, 1'b1);
        convChk(12'h7F0, 16'h0002);
        convChk(12'h7EF, 16'h0000);
        rdReg(3'h0, 16'h07EF);
        chkBit(alertPin, 1'b0);
        $display("test over done");
    endtask

    // Hold keeps flags until one is written; slow converter
    task automatic testHold();
        convLat = 8'd20;
        wrReg(3'h3, 16'h0100);
        wrReg(3'h2, 16'h0018);
        convChk(12'h0FF, 16'h0001);
        chkBit(alertOe, 1'b0);
        convChk(12'h300, 16'h0001);
        rdReg(3'h0, 16'h8300);
        wrReg(3'h2, 16'h0014);
        rdReg(3'h0, 16'h0300);
        chkBit(alertPin, 1'b0);
        wrReg(3'h1, 16'h0001);
        rdReg(3'h1, 16'h0000);
        chkBit(alertPin, 1'b1);
        convChk(12'h900, 16'h0002);
        convChk(12'h100, 16'h0002);
        wrReg(3'h1, 16'h0002);
        rdReg(3'h1, 16'h0000);
        wrReg(3'h2, 16'h0000);
        convChk(12'h0FF, 16'h0001);
        convChk(12'h110, 16'h0001);
        convChk(12'h111, 16'h0000);
        convLat = 8'd3;
        $display("test hold done");
    endtask

    // Every cycle-time code, then code zero stops the starts
    task automatic testInterval();
        int t1;
        int t2;
        for (int c = 1; c < 8; c++) begin
            wrReg(3'h2, {8'h00, 3'(c), 5'h00});
            waitStart(5000, t1);
            waitStart(5000, t1);
            waitStart(5000, t2);
            chk16(16'(t2 - t1), 16'(CONV << (c + 4)));
        end
        wrReg(3'h2, 16'h0000);
        waitStart(20, t1);
        waitStart(300, t1);
        chk16(16'(t1), 16'hFFFF);
        $display("test interval done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence after six reset cycles
    initial begin
        repeat (6) @(posedge clk);
        #1;
        sysRst = 1'b0;
        testReset();
        testReserved();
        testOver();
        testHold();
        testInterval();
        stop_test();
    end

    // Watchdog well past the expected run length
    initial begin
        #800000;
        err_count++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
`default_nettype wire
